// [rtl/ais_pkg.sv]
// constants, field positions and types of the adc input sequencer
package ais_pkg;

    // ==================================================================
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_CTRL1    = 8'h00;
    localparam logic [7:0] OFS_CTRL2    = 8'h04;
    localparam logic [7:0] OFS_CHSEL0   = 8'h08;
    localparam logic [7:0] OFS_CHSEL123 = 8'h0C;
    localparam logic [7:0] OFS_SCAN     = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [1:0] BUF_PAGE     = 2'h1;   // paddr[7:6] of result words

    // ==================================================================
    // first control register fields
    localparam int C1_START  = 0;    // software start of conversion, self clearing
    localparam int C1_SAMP   = 1;    // software sample arm
    localparam int C1_AUTO_SAMPLE_ENABLE   = 2;    // auto_sample_enable
    localparam int C1_SIMULTANEOUS_SAMPLE_SELECT = 3;    // simultaneous_sample_select
    localparam int C1_SRC_LO = 5;    // trigger_source_select, 3 bits
    localparam int C1_RES12  = 10;   // resolution_select
    localparam int C1_DMA    = 12;   // dma transfer mode
    localparam int C1_ON     = 15;   // converter on

    // ==================================================================
    // second control register fields
    localparam int C2_ALT     = 0;   // alt_input_enable
    localparam int C2_SEQUENCES_PER_INTERRUPT_LO = 2;   // sequences_per_interrupt, 4 bits
    localparam int C2_CHANNEL_COUNT_SELECT_LO = 8;   // channel_count_select, 2 bits
    localparam int C2_SCAN    = 10;  // scan_enable

    // ==================================================================
    // input select register fields
    localparam int CS0_POSA_LO   = 0;
    localparam int CS0_NEGA      = 7;
    localparam int CS0_POSB_LO   = 16;
    localparam int CS0_NEGB      = 23;
    localparam int CS123_POSA    = 0;
    localparam int CS123_NEGA_LO = 1;
    localparam int CS123_POSB    = 8;
    localparam int CS123_NEGB_LO = 9;

    // ==================================================================
    // trigger source codes
    localparam logic [2:0] TRG_SW    = 3'h0;
    localparam logic [2:0] TRG_PIN   = 3'h1;
    localparam logic [2:0] TRG_TIMER = 3'h2;
    localparam logic [2:0] TRG_PWM   = 3'h3;
    localparam logic [2:0] TRG_AUTO  = 3'h7;

    // ==================================================================
    // reset values and limits
    localparam logic [31:0] RST_REG     = 32'h0000_0000;
    localparam logic [31:0] NODMA_MASK  = 32'h0000_1FFF;   // inputs 0..12
    localparam logic [4:0]  NODMA_TOP   = 5'h0C;
    localparam logic [4:0]  SCAN_WRAP   = 5'h1F;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_START = 3'b010,
        ST_WAIT  = 3'b100
    } ais_state_t;

endpackage

// [rtl/ais_sequencer.sv]
// input sequencing control of a sar adc with apb register access
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps

module ais_sequencer #(
    parameter int RES_W     = 12,
    parameter int BUF_DEPTH = 16
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_ce,
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [7:0]          i_paddr,
    input  wire logic [31:0]         i_pwdata,
    output logic      [31:0]         o_prdata,
    output logic                     o_pready,
    output logic                     o_pslverr,
    input  wire logic                i_trig_pin,
    input  wire logic                i_timer_trig,
    input  wire logic                i_pwm_trig,
    output logic                     o_conv_start,
    output logic      [1:0]          o_conv_chan,
    input  wire logic                i_conv_done,
    input  wire logic [RES_W-1:0]    i_conv_result,
    output logic      [3:0]          o_sample_en,
    output logic      [4:0]          o_ch0_pos,
    output logic                     o_ch0_neg,
    output logic                     o_ch123_pos,
    output logic      [1:0]          o_ch123_neg,
    output logic                     o_irq
);
    import ais_pkg::*;

    localparam int PTR_W = $clog2(BUF_DEPTH);

    // ==================================================================
    // elaboration checks
    if (BUF_DEPTH < 2 || BUF_DEPTH > 16 || (1 << PTR_W) != BUF_DEPTH) begin : g_bad_depth
        $error("BUF_DEPTH must be a power of two from 2 to 16");
    end
    if (RES_W < 1 || RES_W > 32) begin : g_bad_res
        $error("RES_W must be 1 to 32");
    end

    // ==================================================================
    // functions
    // active channel count from field and resolution
    function automatic logic [2:0] chan_count(input logic [1:0] channel_count_select, input logic res12);
        logic [2:0] n;
        n = 3'h4;
        if (res12 || channel_count_select == 2'h0) begin
            n = 3'h1;
        end else if (channel_count_select == 2'h1) begin
            n = 3'h2;
        end
        return n;
    endfunction

    // lowest enabled input above cur, wrapping; zero when none
    function automatic logic [4:0] next_scan(input logic [31:0] m, input logic [4:0] cur);
        logic [4:0] idx;
        logic [4:0] res;
        res = 5'h00;
        for (int i = 32; i >= 1; i--) begin
            idx = cur + 5'(i);
            if (m[idx]) begin
                res = idx;
            end
        end
        return res;
    endfunction

    // ==================================================================
    // state
    logic [31:0]      ctrl1_q;
    logic [31:0]      ctrl2_q;
    logic [31:0]      chsel0_q;
    logic [31:0]      chsel123_q;
    logic [31:0]      scan_mask_q;
    logic             sw_trig_q;
    logic             sw_samp_q;
    logic             pin_s1_q;
    logic             pin_s2_q;
    logic             pin_s3_q;
    ais_state_t       st_q;
    logic [1:0]       cur_ch_q;
    logic             set_b_q;
    logic [4:0]       scan_idx_q;
    logic             sampling_q;
    logic [3:0]       cnt_q;
    logic [PTR_W-1:0] buf_ptr_q;
    logic [RES_W-1:0] result_mem [BUF_DEPTH];

    // ==================================================================
    // decoded configuration
    logic             on;
    logic             sim;
    logic             alt;
    logic             scan;
    logic             dma;
    logic [3:0]       sequences_per_interrupt;
    logic [2:0]       nchan;
    logic [31:0]      eff_mask;
    logic [4:0]       scan_first;
    logic             last_ch;
    logic             trig;
    logic             go;
    logic             conv_ok;
    logic             sweep_end;
    logic             seq_inc;
    logic             irq_evt;
    logic             restart;
    logic [4:0]       ch0_pos_d;
    logic             ch0_neg_d;
    logic             ch123_pos_d;
    logic [1:0]       ch123_neg_d;
    logic [3:0]       sample_en_d;

    assign on         = ctrl1_q[C1_ON];
    assign sim        = ctrl1_q[C1_SIMULTANEOUS_SAMPLE_SELECT];
    assign dma        = ctrl1_q[C1_DMA];
    assign alt        = ctrl2_q[C2_ALT];
    assign scan       = ctrl2_q[C2_SCAN];
    assign sequences_per_interrupt       = ctrl2_q[C2_SEQUENCES_PER_INTERRUPT_LO +: 4];
    assign nchan      = chan_count(ctrl2_q[C2_CHANNEL_COUNT_SELECT_LO +: 2], ctrl1_q[C1_RES12]);
    assign eff_mask   = dma ? scan_mask_q : (scan_mask_q & NODMA_MASK);
    assign scan_first = next_scan(eff_mask, SCAN_WRAP);
    assign last_ch    = ({1'b0, cur_ch_q} == nchan - 3'h1);

    // trigger source selection
    always_comb begin
        trig = 1'b0;
        unique case (ctrl1_q[C1_SRC_LO +: 3])
            TRG_SW:    trig = sw_trig_q;
            TRG_PIN:   trig = pin_s2_q & ~pin_s3_q;
            TRG_TIMER: trig = i_timer_trig;
            TRG_PWM:   trig = i_pwm_trig;
            TRG_AUTO:  trig = 1'b1;
            default:   trig = 1'b0;
        endcase
    end

    // sweep and sequence events
    assign go        = on & sampling_q & trig & (st_q == ST_IDLE);
    assign conv_ok   = (st_q == ST_WAIT) & i_conv_done;
    assign sweep_end = conv_ok & last_ch;
    assign seq_inc   = sim ? sweep_end : conv_ok;
    // only the programmed count restarts the sequence; the per-conversion
    // dma interrupt must not cut a sweep short or stop the set A/B swap
    assign restart   = seq_inc & (cnt_q == sequences_per_interrupt);
    assign irq_evt   = (dma & alt & conv_ok) | restart;

    // multiplexer selections for the current sweep
    always_comb begin
        if (set_b_q) begin
            ch0_pos_d   = chsel0_q[CS0_POSB_LO +: 5];
            ch0_neg_d   = chsel0_q[CS0_NEGB];
            ch123_pos_d = chsel123_q[CS123_POSB];
            ch123_neg_d = chsel123_q[CS123_NEGB_LO +: 2];
        end else begin
            ch0_pos_d   = scan ? scan_idx_q
                               : chsel0_q[CS0_POSA_LO +: 5];
            ch0_neg_d   = chsel0_q[CS0_NEGA];
            ch123_pos_d = chsel123_q[CS123_POSA];
            ch123_neg_d = chsel123_q[CS123_NEGA_LO +: 2];
        end
    end

    // sample capacitor connection per channel
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (3'(k) >= nchan) begin
                sample_en_d[k] = 1'b0;
            end else if (st_q == ST_IDLE) begin
                sample_en_d[k] = sampling_q & on;
            end else if (sim) begin
                sample_en_d[k] = 1'b0;
            end else begin
                sample_en_d[k] = (2'(k) != cur_ch_q);
            end
        end
    end

    // ==================================================================
    // pin trigger synchroniser and edge detect
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else if (i_ce) begin
            pin_s1_q <= i_trig_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // ==================================================================
    // apb slave: one wait state, commit on the pready edge
    logic        access;
    logic        fire;
    logic        mapped;
    logic [31:0] rdata_d;

    assign access = i_psel & i_penable;
    assign fire   = access & o_pready;

    // read decode
    always_comb begin
        mapped  = 1'b1;
        rdata_d = RST_REG;
        if (i_paddr[7:6] == BUF_PAGE) begin
            if ({1'b0, i_paddr[5:2]} < 5'(BUF_DEPTH)) begin
                rdata_d = 32'(result_mem[i_paddr[2 +: PTR_W]]);
            end else begin
                mapped = 1'b0;
            end
        end else begin
            unique case (i_paddr)
                OFS_CTRL1:    rdata_d = ctrl1_q | (32'(sampling_q) << C1_SAMP);
                OFS_CTRL2:    rdata_d = ctrl2_q;
                OFS_CHSEL0:   rdata_d = chsel0_q;
                OFS_CHSEL123: rdata_d = chsel123_q;
                OFS_SCAN:     rdata_d = scan_mask_q;
                OFS_STATUS:   rdata_d = {16'h0000, sampling_q, (st_q != ST_IDLE), cnt_q,
                                         4'(buf_ptr_q), set_b_q, scan_idx_q};
                default:      mapped = 1'b0;
            endcase
        end
    end

    // bus answer registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= RST_REG;
        end else if (i_ce) begin
            o_pready  <= access & ~o_pready;
            o_pslverr <= access & ~o_pready & ~mapped;
            if (access & ~o_pready & ~i_pwrite) begin
                o_prdata <= rdata_d;
            end
        end
    end

    // register writes; start bit is a pulse and reads back as 0, sample-arm bit reads back as state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl1_q     <= RST_REG;
            ctrl2_q     <= RST_REG;
            chsel0_q    <= RST_REG;
            chsel123_q  <= RST_REG;
            scan_mask_q <= RST_REG;
            sw_trig_q   <= 1'b0;
            sw_samp_q   <= 1'b0;
        end else if (i_ce) begin
            sw_trig_q <= 1'b0;
            sw_samp_q <= 1'b0;
            if (fire & i_pwrite & ~o_pslverr) begin
                unique case (i_paddr)
                    OFS_CTRL1: begin
                        ctrl1_q   <= i_pwdata & ~((32'h1 << C1_START) | (32'h1 << C1_SAMP));
                        sw_trig_q <= i_pwdata[C1_START];
                        sw_samp_q <= i_pwdata[C1_SAMP];
                    end
                    OFS_CTRL2:    ctrl2_q     <= i_pwdata;
                    OFS_CHSEL0:   chsel0_q    <= i_pwdata;
                    OFS_CHSEL123: chsel123_q  <= i_pwdata;
                    OFS_SCAN:     scan_mask_q <= i_pwdata;
                    default:      ;
                endcase
            end
        end
    end

    // ==================================================================
    // sweep sequencer: channels, set A/B, scan pointer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q         <= ST_IDLE;
            cur_ch_q     <= 2'h0;
            set_b_q      <= 1'b0;
            scan_idx_q   <= 5'h00;
            sampling_q   <= 1'b0;
            o_conv_start <= 1'b0;
        end else if (i_ce) begin
            o_conv_start <= 1'b0;
            if (!on) begin
                st_q       <= ST_IDLE;
                cur_ch_q   <= 2'h0;
                set_b_q    <= 1'b0;
                scan_idx_q <= scan_first;
            end else begin
                unique case (st_q)
                    ST_IDLE: begin
                        if (go) begin
                            cur_ch_q <= 2'h0;
                            st_q     <= ST_START;
                        end
                    end
                    ST_START: begin
                        o_conv_start <= 1'b1;
                        st_q         <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (restart) begin
                            st_q       <= ST_IDLE;
                            cur_ch_q   <= 2'h0;
                            set_b_q    <= 1'b0;
                            scan_idx_q <= scan_first;
                            sampling_q <= ctrl1_q[C1_AUTO_SAMPLE_ENABLE];
                        end else if (sweep_end) begin
                            st_q       <= ST_IDLE;
                            cur_ch_q   <= 2'h0;
                            set_b_q    <= alt & ~set_b_q;
                            sampling_q <= ctrl1_q[C1_AUTO_SAMPLE_ENABLE];
                            if (scan && !set_b_q) begin
                                scan_idx_q <= next_scan(eff_mask, scan_idx_q);
                            end
                        end else if (conv_ok) begin
                            cur_ch_q <= cur_ch_q + 2'h1;
                            st_q     <= ST_START;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
            // software arm wins over the end-of-sweep clear
            if (sw_samp_q) begin
                sampling_q <= 1'b1;
            end
        end
    end

    // ==================================================================
    // sequence counter, result buffer pointer, conversion interrupt
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q     <= 4'h0;
            buf_ptr_q <= '0;
            o_irq     <= 1'b0;
        end else if (i_ce) begin
            o_irq <= on & irq_evt;
            if (!on) begin
                cnt_q     <= 4'h0;
                buf_ptr_q <= '0;
            end else if (conv_ok) begin
                cnt_q     <= restart ? 4'h0 : cnt_q + 4'(seq_inc);
                buf_ptr_q <= (restart | dma) ? '0 : buf_ptr_q + 1'b1;
            end
        end
    end

    // result storage in conversion order; with dma the pointer returns to word 0 after every result
    always_ff @(posedge i_clk) begin
        if (i_ce && conv_ok) begin
            result_mem[buf_ptr_q] <= i_conv_result;
        end
    end

    // registered multiplexer and capacitor controls
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sample_en <= 4'h0;
            o_ch0_pos   <= 5'h00;
            o_ch0_neg   <= 1'b0;
            o_ch123_pos <= 1'b0;
            o_ch123_neg <= 2'h0;
            o_conv_chan <= 2'h0;
        end else if (i_ce) begin
            o_sample_en <= sample_en_d;
            o_ch0_pos   <= ch0_pos_d;
            o_ch0_neg   <= ch0_neg_d;
            o_ch123_pos <= ch123_pos_d;
            o_ch123_neg <= ch123_neg_d;
            o_conv_chan <= cur_ch_q;
        end
    end

    // ==================================================================
    // assertions
    default clocking cb @(posedge i_clk iff i_ce);
    endclocking
    default disable iff (i_rst);

    a_irq_clears_count: assert property (restart |=> cnt_q == 4'h0)
        else $error("count not cleared at interrupt");
    a_irq_restart_seq: assert property (restart |=> !set_b_q && buf_ptr_q == '0
        && st_q == ST_IDLE) else $error("sequence not restarted at interrupt");
    a_count_reach: assert property (seq_inc && cnt_q == sequences_per_interrupt && on |=> o_irq)
        else $error("interrupt missing at programmed count");
    a_chan_limit: assert property (st_q == ST_START |-> {1'b0, cur_ch_q} < nchan)
        else $error("channel beyond active count");
    a_first_chan: assert property (go |=> st_q == ST_START && cur_ch_q == 2'h0)
        else $error("sweep did not start at channel 0");
    a_sim_disconnect: assert property (sim && st_q != ST_IDLE |-> sample_en_d == 4'h0)
        else $error("capacitor connected during simultaneous convert");
    a_start_pulse: assert property (st_q == ST_START |=> o_conv_start ##1 !o_conv_start)
        else $error("conversion start not a single pulse");
    a_scan_mux: assert property (scan && !set_b_q |-> ch0_pos_d == scan_idx_q)
        else $error("scan pointer not driving channel 0");
    a_setb_mux: assert property (set_b_q |-> ch0_pos_d == chsel0_q[CS0_POSB_LO +: 5])
        else $error("set B selection not used");
    a_dma_alt_irq: assert property (dma && alt && conv_ok && on |=> o_irq)
        else $error("no interrupt per conversion in dma alt mode");
    a_scan_range: assert property (scan && !dma && on |-> scan_idx_q <= NODMA_TOP)
        else $error("scan input beyond limit without dma");
    a_alt_toggle: assert property (sweep_end && !restart && alt && on
        |=> set_b_q != $past(set_b_q)) else $error("alternate sweep did not swap sets");

    c_irq:      cover property (o_irq && !dma);
    c_sim_sweep: cover property (sim && sweep_end && nchan == 3'h4);
    c_scan_step: cover property (scan && sweep_end && !set_b_q && !irq_evt);
    c_set_b:    cover property (alt && set_b_q && conv_ok);

endmodule

// [testbench/ais_conv_model.sv]
// converter model that answers each start with a counted result
`timescale 1ns/1ps

module ais_conv_model #(
    parameter int DLY = 3
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    output logic             o_done,
    output logic      [11:0] o_result
);
    logic [11:0] cnt_q;
    int          wait_q;

    // count down after a start, then pulse done with the next count
    always_ff @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_rst) begin
            cnt_q  <= 12'h000;
            wait_q <= 0;
        end else if (i_start) begin
            wait_q <= DLY;
        end else if (wait_q == 1) begin
            wait_q <= 0;
            o_done <= 1'b1;
            cnt_q  <= cnt_q + 12'h001;
        end else if (wait_q > 1) begin
            wait_q <= wait_q - 1;
        end
    end

    // result lines carry junk outside the done cycle
    assign o_result = o_done ? cnt_q : ~cnt_q;
endmodule

// [testbench/ais_sequencer_bench.sv]
// testbench of the adc input sequencer
`timescale 1ns/1ps

module ais_sequencer_bench;
    import ais_pkg::*;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
    logic        i_pwrite = 1'b0, i_timer_trig = 1'b0, i_pwm_trig = 1'b0, i_trig_pin = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic        o_pready, o_pslverr, o_conv_start, i_conv_done, er;
    logic        o_ch0_neg, o_ch123_pos, o_irq;
    logic [1:0]  o_conv_chan, o_ch123_neg;
    logic [3:0]  o_sample_en;
    logic [4:0]  o_ch0_pos;
    logic [11:0] i_conv_result;
    logic [31:0] pos_q[$], chan_q[$], c123_q[$], sen_q[$];
    logic [4:0]  scan_exp [5] = '{5'h02, 5'h03, 5'h05, 5'h06, 5'h02};
    int          errors = 0, compares = 0, irqs = 0;

    // ====
    // clock, design and converter
    always #2.5 i_clk = ~i_clk;

    ais_sequencer #(.RES_W(12), .BUF_DEPTH(16)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_trig_pin(i_trig_pin), .i_timer_trig(i_timer_trig),
        .i_pwm_trig(i_pwm_trig), .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan),
        .i_conv_done(i_conv_done), .i_conv_result(i_conv_result),
        .o_sample_en(o_sample_en), .o_ch0_pos(o_ch0_pos), .o_ch0_neg(o_ch0_neg),
        .o_ch123_pos(o_ch123_pos), .o_ch123_neg(o_ch123_neg), .o_irq(o_irq));

    ais_conv_model cm_u (.i_clk(i_clk), .i_rst(i_rst), .i_start(o_conv_start),
        .o_done(i_conv_done), .o_result(i_conv_result));

    // record selections at each conversion start, count interrupts
    always @(posedge i_clk) begin
        if (o_conv_start === 1'b1) begin
            pos_q.push_back({27'h0, o_ch0_pos});
            chan_q.push_back({30'h0, o_conv_chan});
            c123_q.push_back({31'h0, o_ch123_pos});
            sen_q.push_back({28'h0, o_sample_en});
        end
        if (o_irq === 1'b1) irqs++;
    end

    // ====
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel   <= 1'b1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        // only the watchdog ends a wait for the slave
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic sweep(input int n);
        int t;
        t = pos_q.size() + n;
        @(posedge i_clk);
        i_timer_trig <= 1'b1;
        i_trig_pin   <= 1'b1;
        @(posedge i_clk);
        i_timer_trig <= 1'b0;
        i_trig_pin   <= 1'b0;
        for (int k = 0; k < 300 && pos_q.size() < t; k++) @(posedge i_clk);
        repeat (12) @(posedge i_clk);
    endtask

    task automatic close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ====
    // test sequence
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OFS_CHSEL0, 32'h0007_0006);
        apb(1'b1, OFS_CHSEL123, 32'h0000_0100);
        apb(1'b1, OFS_CTRL2, 32'h0000_010D);
        apb(1'b1, OFS_CTRL1, 32'h0000_8046);
        i_pwm_trig <= 1'b1;
        repeat (20) @(posedge i_clk);
        i_pwm_trig <= 1'b0;
        chk(pos_q.size(), 32'h0);
        sweep(2);
        chk(irqs, 32'h0);
        sweep(2);
        chk(irqs, 32'h1);
        for (int k = 0; k < 4; k++) begin
            chk(pos_q[k], (k < 2) ? 32'h6 : 32'h7);
            chk(chan_q[k], 32'(k % 2));
            chk(c123_q[k], 32'(k / 2));
            apb(1'b0, 8'(8'h40 + 4 * k), 32'h0);
            chk(rd, 32'(k + 1));
        end
        sweep(2);
        chk(pos_q[4], 32'h6);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h5);
        apb(1'b1, OFS_CTRL1, 32'h0);
        apb(1'b1, OFS_CTRL2, 32'h0000_040C);
        apb(1'b1, OFS_SCAN, 32'h0010_006C);
        apb(1'b1, OFS_CTRL1, 32'h0000_8046);
        pos_q.delete();
        chan_q.delete();
        irqs = 0;
        for (int k = 0; k < 5; k++) sweep(1);
        for (int k = 0; k < 5; k++) begin
            chk(pos_q[k], {27'h0, scan_exp[k]});
            chk(chan_q[k], 32'h0);
        end
        chk(irqs, 32'h1);
        apb(1'b1, OFS_CTRL1, 32'h0);
        apb(1'b1, OFS_CTRL2, 32'h0000_0100);
        apb(1'b1, OFS_CTRL1, 32'h0000_804E);
        sen_q.delete();
        chan_q.delete();
        irqs = 0;
        sweep(2);
        chk(sen_q[0] & 32'h3, 32'h0);
        chk(chan_q[1], 32'h1);
        chk(irqs, 32'h1);
        // dma alternate mode, two-channel simultaneous, pin trigger
        apb(1'b1, OFS_CTRL1, 32'h0);
        apb(1'b1, OFS_CTRL2, 32'h0000_0105);
        apb(1'b1, OFS_CTRL1, 32'h0000_902E);
        pos_q.delete();
        irqs = 0;
        for (int k = 0; k < 3; k++) sweep(2);
        chk(pos_q[0], 32'h6);
        chk(pos_q[2], 32'h7);
        chk(pos_q[4], 32'h6);
        chk(irqs, 32'h6);
        close_out;
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        close_out;
    end
endmodule
